// file: core/tdu_trigger_delay_unit.sv
// Programmable trigger delay unit with APB register slave
//
// Contract
// - Start only on rising trigger edge
// - Select field picks soft, analog, digital trigger
// - Soft kick restarts counter, reads zero
// - Counter runs only while enabled
// - Disabled: counter stopped, outputs low
// - One-shot: restart from one, one transition
// - Repeat mode: roll over at period, continue
// - Period match resets count, one-shot stops
// - Bit four selects one-shot or repeat
// - First delay equals ratio times value plus one
// - Second delay equals ratio times value plus one
// - Pulse output adds one more cycle
// - Three-bit divider, code five divides six
// - Divider stretches output pulse widths
// - Second hit flag sticky, write one clears
// - First hit flag sticky, write one clears
// - Second interrupt follows flag and enable
// - First interrupt follows flag and enable
// - Second output select: zero, compare, pulse
// - First output select: zero, compare, pulse
// - Pulse rises on first, falls on second
// - Count starts at one; zero delay never matches
// - Retrigger during count restarts counter
module tdu_trigger_delay_unit
    import tdu_pkg::*;
(
    input  wire logic               clk,          // Peripheral clock, 50 MHz
    input  wire logic               reset,        // Synchronous, active high
    input  wire logic               psel,         // APB select
    input  wire logic               penable,      // APB access phase
    input  wire logic               pwrite,       // APB direction
    input  wire logic [31:0]        paddr,        // APB byte address
    input  wire logic [31:0]        pwdata,       // APB write data
    output logic      [31:0]        prdata,       // APB read data
    output logic                    pready,       // APB ready
    output logic                    pslverr,      // APB error, unmapped address
    input  wire logic               analogStart,  // Analog phase start level
    input  wire logic               digitalStart, // Digital phase start level
    output logic                    outA,         // First delayed output
    output logic                    outB,         // Second delayed output
    output logic                    irqA,         // First interrupt
    output logic                    irqB          // Second interrupt
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [15:0] ctrl;            // Control bits, flags kept separately
    logic [15:0] dlyA;            // First output delay
    logic [15:0] dlyB;            // Second output delay
    logic [15:0] period;          // Count period
    logic [15:0] count;           // Running count
    logic        hitA;            // First hit flag
    logic        hitB;            // Second hit flag
    tdu_run_t    runState;        // Counting or idle
    logic [6:0]  preCnt;          // Prescaler counter
    logic        cmpA;            // First compare signal
    logic        cmpB;            // Second compare signal
    logic        pulse;           // Pulse output
    logic [1:0]  syncA;           // Analog start synchroniser
    logic [1:0]  syncD;           // Digital start synchroniser
    logic        prevTrig;        // Previous selected trigger level

    // ------------------------------------------------------------
    // Decoded fields and bus strobes
    // ------------------------------------------------------------
    logic        enable;          // Module enable
    logic        repeatMode;      // Repeat mode
    logic [1:0]  tsel;            // Trigger source select
    logic [1:0]  aSel;            // First output select
    logic [1:0]  bSel;            // Second output select
    logic [2:0]  divSel;          // Clock divide select
    logic [6:0]  divM1;           // Divide ratio minus one
    logic        tick;            // Prescaled count enable
    logic        hwTrigLvl;       // Selected hardware trigger level
    logic        trigEdge;        // Start or restart event
    logic        busAccess;       // Access phase completes
    logic        wrCtrl;          // Control write strobe
    logic        mapped;          // Address decodes to a register
    logic        hitEqA;          // Count equals first delay
    logic        hitEqB;          // Count equals second delay

    assign enable     = ctrl[BIT_EN];
    assign repeatMode = ctrl[BIT_REPEAT];
    assign tsel       = ctrl[BIT_TSEL_LO +: 2];
    assign aSel       = ctrl[BIT_AOS_LO +: 2];
    assign bSel       = ctrl[BIT_BOS_LO +: 2];
    assign divSel     = ctrl[BIT_DIV_LO +: 3];
    assign busAccess  = psel && penable;
    assign wrCtrl     = busAccess && pwrite && mapped && paddr[ADDR_W-1:0] == ADDR_CTRL;

    // Unmapped addresses answer with pslverr; they read zero unless the low six bits match a register
    assign mapped = paddr[31:ADDR_W] == '0 &&
                    (paddr[ADDR_W-1:0] == ADDR_CTRL  || paddr[ADDR_W-1:0] == ADDR_DLY_A ||
                     paddr[ADDR_W-1:0] == ADDR_DLY_B || paddr[ADDR_W-1:0] == ADDR_PERIOD ||
                     paddr[ADDR_W-1:0] == ADDR_COUNT);

    // ------------------------------------------------------------
    // Divider ratio lookup
    // ------------------------------------------------------------
    // Code five is kept as a divide by six, as the part behaves
    always_comb
    begin
        case (divSel)
            3'h0:    divM1 = DIV_M1_0;
            3'h1:    divM1 = DIV_M1_1;
            3'h2:    divM1 = DIV_M1_2;
            3'h3:    divM1 = DIV_M1_3;
            3'h4:    divM1 = DIV_M1_4;
            3'h5:    divM1 = DIV_M1_5;
            3'h6:    divM1 = DIV_M1_6;
            default: divM1 = DIV_M1_7;
        endcase
    end

    // ------------------------------------------------------------
    // Trigger selection and edge detection
    // ------------------------------------------------------------
    // Phase starts come from another block; two flops before use
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            syncA <= 2'b00;
            syncD <= 2'b00;
        end
        else
        begin
            syncA <= {syncA[0], analogStart};
            syncD <= {syncD[0], digitalStart};
        end
    end

    // Reserved select gives no trigger
    always_comb
    begin
        case (tsel)
            TSEL_ANALOG:  hwTrigLvl = syncA[1];
            TSEL_DIGITAL: hwTrigLvl = syncD[1];
            default:      hwTrigLvl = 1'b0;
        endcase
    end

    // Previous level, for rising edge detect
    always_ff @(posedge clk)
    begin
        if (reset)
            prevTrig <= 1'b0;
        else
            prevTrig <= hwTrigLvl;
    end

    // Only edges start the counter; a held level does nothing more
    assign trigEdge = enable &&
        ((hwTrigLvl && !prevTrig) ||
         (wrCtrl && tsel == TSEL_SOFT && pwdata[BIT_KICK] &&
          pwdata[BIT_EN]));

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    // Restarted with each trigger so delays stay whole multiples
    always_ff @(posedge clk)
    begin
        if (reset || !enable || trigEdge || runState == RUN_IDLE)
            preCnt <= 7'h00;
        else if (preCnt >= divM1)
            preCnt <= 7'h00;
        else
            preCnt <= preCnt + 7'h01;
    end

    assign tick = runState == RUN_COUNT && preCnt >= divM1;

    // ------------------------------------------------------------
    // Counter and run state
    // ------------------------------------------------------------
    // Count enters one on the trigger edge; compare flops load on
    // ticks, so value N shows N ticks later, the output flop one more
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count    <= RST_COUNT;
            runState <= RUN_IDLE;
        end
        else if (!enable)
            runState <= RUN_IDLE;
        else if (trigEdge)
        begin
            count    <= COUNT_START;
            runState <= RUN_COUNT;
        end
        else if (tick)
        begin
            if (count == period)
            begin
                count    <= 16'h0000;
                runState <= repeatMode ? RUN_COUNT : RUN_IDLE;
            end
            else if (count == 16'h0000)
                count <= COUNT_START;
            else
                count <= count + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    // Compare signals stand one prescaled period, so the divider
    // also sets their width
    assign hitEqA = runState == RUN_COUNT && count == dlyA && count != 16'h0000;
    assign hitEqB = runState == RUN_COUNT && count == dlyB && count != 16'h0000;

    always_ff @(posedge clk)
    begin
        if (reset || !enable)
        begin
            cmpA <= 1'b0;
            cmpB <= 1'b0;
        end
        else if (trigEdge || tick || runState == RUN_IDLE)
        begin
            cmpA <= hitEqA && !trigEdge;
            cmpB <= hitEqB && !trigEdge;
        end
    end

    // Pulse stage: one more flop, hence one more cycle of latency
    always_ff @(posedge clk)
    begin
        if (reset || !enable)
            pulse <= 1'b0;
        else if (cmpB)
            pulse <= 1'b0;
        else if (cmpA)
            pulse <= 1'b1;
    end

    // ------------------------------------------------------------
    // Output selection, registered
    // ------------------------------------------------------------
    // Registering keeps A and B free of decode glitches
    always_ff @(posedge clk)
    begin
        if (reset || !enable)
        begin
            outA <= 1'b0;
            outB <= 1'b0;
        end
        else
        begin
            case (aSel)
                OSEL_CMP:   outA <= cmpA;
                OSEL_PULSE: outA <= pulse;
                default:    outA <= 1'b0;
            endcase
            case (bSel)
                OSEL_CMP:   outB <= cmpB;
                OSEL_PULSE: outB <= pulse;
                default:    outB <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sticky flags and interrupts
    // ------------------------------------------------------------
    // A new hit in the clearing cycle wins over the clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            hitA <= 1'b0;
            hitB <= 1'b0;
        end
        else
        begin
            if (cmpA)
                hitA <= 1'b1;
            else if (wrCtrl && pwdata[BIT_HIT_A])
                hitA <= 1'b0;
            if (cmpB)
                hitB <= 1'b1;
            else if (wrCtrl && pwdata[BIT_HIT_B])
                hitB <= 1'b0;
        end
    end

    // Interrupt lines follow flag and enable, one flop later
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irqA <= 1'b0;
            irqB <= 1'b0;
        end
        else
        begin
            irqA <= hitA && ctrl[BIT_IEN_A];
            irqB <= hitB && ctrl[BIT_IEN_B];
        end
    end

    // ------------------------------------------------------------
    // APB register writes
    // ------------------------------------------------------------
    // Writes while enabled are taken; keeping them to idle time is
    // up to software
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl   <= RST_CTRL;
            dlyA   <= RST_DLY;
            dlyB   <= RST_DLY;
            period <= RST_PERIOD;
        end
        else if (busAccess && pwrite && mapped)
        begin
            case (paddr[ADDR_W-1:0])
                ADDR_CTRL:
                begin
                    // Kick and flag bits are not stored here
                    ctrl <= pwdata[15:0] & ~16'h1808;
                end
                ADDR_DLY_A:  dlyA   <= pwdata[15:0];
                ADDR_DLY_B:  dlyB   <= pwdata[15:0];
                ADDR_PERIOD: period <= pwdata[15:0];
                default:     ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // APB read data and answer
    // ------------------------------------------------------------
    // Zero wait states; data registered at the access edge
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                case (paddr[ADDR_W-1:0])
                    ADDR_CTRL:   prdata <= {16'h0000, ctrl | {3'h0, hitB, hitA, 11'h000}};
                    ADDR_DLY_A:  prdata <= {16'h0000, dlyA};
                    ADDR_DLY_B:  prdata <= {16'h0000, dlyB};
                    ADDR_PERIOD: prdata <= {16'h0000, period};
                    ADDR_COUNT:  prdata <= {16'h0000, count};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_kick;
        wrCtrl && tsel == TSEL_SOFT && pwdata[BIT_KICK] && pwdata[BIT_EN] && enable;
    endsequence

    sequence s_started;
        ##1 (count == COUNT_START && runState == RUN_COUNT);
    endsequence

    a_kick_restart: assert property (@(posedge clk) disable iff (reset)
        s_kick |-> s_started)
        else $error("soft kick did not restart count");

    a_disabled_low: assert property (@(posedge clk) disable iff (reset)
        !enable ##1 !enable |-> !outA && !outB && !pulse)
        else $error("outputs not low while disabled");

    a_stop_idle: assert property (@(posedge clk) disable iff (reset)
        !enable |=> runState == RUN_IDLE)
        else $error("counter runs while disabled");

    a_oneshot_stop: assert property (@(posedge clk) disable iff (reset)
        enable && tick && count == period && !repeatMode && !trigEdge
        |=> runState == RUN_IDLE && count == 16'h0000)
        else $error("one-shot did not stop at period");

    a_repeat_roll: assert property (@(posedge clk) disable iff (reset)
        enable && tick && count == period && repeatMode && !trigEdge
        |=> runState == RUN_COUNT && count == 16'h0000)
        else $error("repeat mode did not roll over");

    a_hitA_sticky: assert property (@(posedge clk) disable iff (reset)
        cmpA |=> hitA)
        else $error("first hit flag not set");

    a_hitB_sticky: assert property (@(posedge clk) disable iff (reset)
        hitB && !(wrCtrl && pwdata[BIT_HIT_B]) |=> hitB)
        else $error("second hit flag lost");

    a_irq_follow: assert property (@(posedge clk) disable iff (reset)
        hitA && ctrl[BIT_IEN_A] |=> irqA)
        else $error("first interrupt missing");

    a_level_nostart: assert property (@(posedge clk) disable iff (reset)
        tsel != TSEL_SOFT && $stable(hwTrigLvl) |-> !trigEdge)
        else $error("start without a rising edge");

    a_delay_one: assert property (@(posedge clk) disable iff (reset)
        trigEdge && divSel == 3'h0 && dlyA == 16'h0002 && period > 16'h0002
        && aSel == OSEL_CMP ##1 !trigEdge && enable [*3]
        |=> outA)
        else $error("first output delay wrong");

endmodule // tdu_trigger_delay_unit

// file: shared/tdu_pkg.sv
// Package of register map, field positions and codes for the trigger delay unit
package tdu_pkg;

    // ------------------------------------------------------------
    // Register indices (printed offsets) and byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0]  IDX_CTRL     = 4'h0;   // Control and status
    localparam logic [3:0]  IDX_DLY_A    = 4'h2;   // First output delay
    localparam logic [3:0]  IDX_DLY_B    = 4'h4;   // Second output delay
    localparam logic [3:0]  IDX_PERIOD   = 4'h6;   // Count period
    localparam logic [3:0]  IDX_COUNT    = 4'h8;   // Count value

    localparam int          ADDR_W       = 6;      // Byte address width decoded
    localparam logic [5:0]  ADDR_CTRL    = {IDX_CTRL, 2'b00};
    localparam logic [5:0]  ADDR_DLY_A   = {IDX_DLY_A, 2'b00};
    localparam logic [5:0]  ADDR_DLY_B   = {IDX_DLY_B, 2'b00};
    localparam logic [5:0]  ADDR_PERIOD  = {IDX_PERIOD, 2'b00};
    localparam logic [5:0]  ADDR_COUNT   = {IDX_COUNT, 2'b00};

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int BIT_EN       = 0;   // Module enable
    localparam int BIT_TSEL_LO  = 1;   // Trigger source select, 2 bits
    localparam int BIT_KICK     = 3;   // Soft kick, reads zero
    localparam int BIT_REPEAT   = 4;   // Repeat mode
    localparam int BIT_AOS_LO   = 5;   // First output select, 2 bits
    localparam int BIT_BOS_LO   = 7;   // Second output select, 2 bits
    localparam int BIT_IEN_A    = 9;   // First irq enable
    localparam int BIT_IEN_B    = 10;  // Second irq enable
    localparam int BIT_HIT_A    = 11;  // First hit flag
    localparam int BIT_HIT_B    = 12;  // Second hit flag
    localparam int BIT_DIV_LO   = 13;  // Clock divide select, 3 bits

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CTRL    = 16'h0000;
    localparam logic [15:0] RST_DLY     = 16'h0000;
    localparam logic [15:0] RST_PERIOD  = 16'hffff;
    localparam logic [15:0] RST_COUNT   = 16'hffff;
    localparam logic [15:0] COUNT_START = 16'h0001;   // First value after start

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TSEL_SOFT    = 2'b00,
        TSEL_ANALOG  = 2'b01,
        TSEL_DIGITAL = 2'b10,
        TSEL_RSVD    = 2'b11
    } tdu_tsel_t;

    typedef enum logic [1:0] {
        OSEL_ZERO  = 2'b00,
        OSEL_CMP   = 2'b01,
        OSEL_PULSE = 2'b10,
        OSEL_RSVD  = 2'b11
    } tdu_osel_t;

    typedef enum logic [0:0] {
        RUN_IDLE  = 1'b0,
        RUN_COUNT = 1'b1
    } tdu_run_t;

    // Divide ratio minus one per divide code; code 101 divides by six
    localparam logic [6:0] DIV_M1_0 = 7'h00;
    localparam logic [6:0] DIV_M1_1 = 7'h01;
    localparam logic [6:0] DIV_M1_2 = 7'h03;
    localparam logic [6:0] DIV_M1_3 = 7'h07;
    localparam logic [6:0] DIV_M1_4 = 7'h0f;
    localparam logic [6:0] DIV_M1_5 = 7'h05;
    localparam logic [6:0] DIV_M1_6 = 7'h3f;
    localparam logic [6:0] DIV_M1_7 = 7'h7f;

endpackage : tdu_pkg

// file: dv/tdu_phase_model.sv
// Model of the frame phase start sources and the consumer of the first output
module tdu_phase_model
(
    input  wire logic clk,                 // Peripheral clock
    input  wire logic reset,               // Bench reset
    input  wire logic fireAn,              // Bench asks for an analog start
    input  wire logic fireDg,              // Bench asks for a digital start
    input  wire logic outA,                // First output, watched
    output logic      analogStart = 1'b0,  // Analog phase start level
    output logic      digitalStart = 1'b0, // Digital phase start level
    output int        risesA = 0           // Rising edges seen on outA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lastA = 1'b0; // OutA one edge ago
    // Levels move only after edges, as the clock generator would drive them
    always @(posedge clk)
    begin
        analogStart  <= fireAn & ~reset;
        digitalStart <= fireDg & ~reset;
        lastA        <= outA;
        risesA       <= reset ? 0 : risesA + int'(outA & ~lastA);
    end
endmodule // tdu_phase_model

// file: dv/tb_top.sv
// Self-checking bench of the trigger delay unit
module tb_top
    import tdu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        fireAn = 1'b0, fireDg = 1'b0, pready, pslverr, er, watchB = 1'b0;
    logic        analogStart, digitalStart, outA, outB, irqA, irqB;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    int          risesA, n_mismatch = 0, samples_checked = 0, n, r0, d, c;
    tdu_trigger_delay_unit i_tdu_trigger_delay_unit (.clk, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .analogStart,
        .digitalStart, .outA, .outB, .irqA, .irqB);
    tdu_phase_model i_tdu_phase_model (.clk, .reset, .fireAn, .fireDg, .outA,
        .analogStart, .digitalStart, .risesA);
    initial forever #10 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Divide ratio per divide code; code five divides by six
    function automatic int ratio(input int code);
        return code == 5 ? 6 : 1 << code;
    endfunction
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {26'h0, a};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            conclude();
        end
    endtask
    // Cycles while the watched output equals lvl, bounded
    task automatic hold(input logic lvl, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        while ((watchB ? outB : outA) === lvl && cnt < 400);
        if ((watchB ? outB : outA) === lvl)
        begin
            n_mismatch++;
            conclude();
        end
    endtask
    initial
    begin
        void'($urandom(32'hbc0b));
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // Reset values, then an unmapped word that must be refused
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, i < 5 ? 6'(i * 8) : 6'h04, 32'h0);
            check("reset read", rd, (i == 3 || i == 4) ? 32'hffff : 32'h0);
            check("slave error", er, i == 5);
        end
        $display("test reset done");
        // Soft kick with random delays, flag and interrupt
        for (int i = 0; i < 4; i++)
        begin
            d = i == 0 ? 1 : i == 1 ? 2 : $urandom_range(20, 2);
            apb(1'b1, ADDR_CTRL, 32'h0);
            apb(1'b1, ADDR_DLY_A, d);
            apb(1'b1, ADDR_CTRL, 32'h0221);
            apb(1'b1, ADDR_CTRL, 32'h0229);
            hold(1'b0, n);
            check("first latency", n, d + 1);
            hold(1'b1, n);
            check("first width", n, 1);
            check("first irq", irqA, 1'b1);
            apb(1'b0, ADDR_CTRL, 32'h0);
            check("flags", rd, 32'h0a21);
            apb(1'b1, ADDR_CTRL, 32'h0a21);
            apb(1'b0, ADDR_CTRL, 32'h0);
            check("flag clear", rd, 32'h0221);
            check("irq clear", irqA, 1'b0);
        end
        $display("test soft kick done");
        // One-shot gives one pulse, repeat mode a stream
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_PERIOD, 32'h8);
        apb(1'b1, ADDR_DLY_A, 32'h3);
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, ADDR_CTRL, 32'h0);
            apb(1'b1, ADDR_CTRL, m ? 32'h0031 : 32'h0021);
            r0 = risesA;
            apb(1'b1, ADDR_CTRL, m ? 32'h0039 : 32'h0029);
            repeat (60) @(posedge clk);
            n = risesA - r0;
            check("pulses", m ? (n >= 6 && n <= 7) : n, 1);
        end
        $display("test modes done");
        // Every trigger select, source held high as a level
        apb(1'b1, ADDR_CTRL, 32'h0);
        for (int t = 0; t < 4; t++)
        begin
            apb(1'b1, ADDR_CTRL, 32'h0021 | (t << 1));
            r0 = risesA;
            fireAn <= t == 1 || t == 3;
            fireDg <= t != 1;
            repeat (40) @(posedge clk);
            fireAn <= 1'b0;
            fireDg <= 1'b0;
            repeat (20) @(posedge clk);
            check("trigger", risesA - r0, t == 1 || t == 2);
        end
        $display("test triggers done");
        // Kick while disabled does nothing
        apb(1'b1, ADDR_CTRL, 32'h0020);
        r0 = risesA;
        apb(1'b1, ADDR_CTRL, 32'h0028);
        repeat (30) @(posedge clk);
        check("disabled", risesA - r0, 0);
        // Pulse placed by both comparators
        apb(1'b1, ADDR_DLY_B, 32'h7);
        apb(1'b1, ADDR_CTRL, 32'h0041);
        apb(1'b1, ADDR_CTRL, 32'h0049);
        hold(1'b0, n);
        check("pulse latency", n, 3 + 2);
        hold(1'b1, n);
        check("pulse width", n, 4);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("both flags", rd, 32'h1841);
        $display("test pulse done");
        // Divided clock on both outputs; code five always included
        for (int j = 0; j < 2; j++)
        begin
            c = j ? $urandom_range(7, 1) : 5;
            apb(1'b1, ADDR_CTRL, 32'h0);
            apb(1'b1, ADDR_DLY_A, 32'h2);
            apb(1'b1, ADDR_DLY_B, 32'h3);
            apb(1'b1, ADDR_CTRL, 32'h04a1 | (c << 13));
            apb(1'b1, ADDR_CTRL, 32'h04a9 | (c << 13));
            hold(1'b0, n);
            check("divided latency", n, 2 * ratio(c) + 1);
            check("second early", outB, 1'b0);
            hold(1'b1, n);
            check("divided width", n, ratio(c));
            check("second rise", outB, 1'b1);
            watchB = 1'b1;
            hold(1'b1, n);
            watchB = 1'b0;
            check("second width", n, ratio(c));
            check("second irq", irqB, 1'b1);
            apb(1'b1, ADDR_CTRL, 32'h14a1 | (c << 13));
            apb(1'b0, ADDR_CTRL, 32'h0);
            check("second clear", rd, 32'h0ca1 | (c << 13));
            check("second irq clear", irqB, 1'b0);
        end
        $display("test divider done");
        conclude();
    end
endmodule // tb_top
